// file: shared/sign_set_acc_pkg.sv
/*
  Constants, field positions, encodings and helper functions for the
  sign-extend / set-all-ones / accumulator-shift datapath.
  Assumes the core supplies a full 24-bit instruction word per cycle.

  // Function
  // - sign-extend copies low byte, fills upper byte with ones if bit 7 set.
  // - sign-extend updates N, Z, C; carry is the inverse of negative.
  // - sign-extend source any mode; destination is a directly addressed register.
  // - sign-extend source pointer steps by one on increment or decrement.
  // - set-all-ones writes 0xFF or 0xFFFF and leaves flags untouched.
  // - file form destination bit 0 picks default register, 1 the file register.
  // - size bit 0 means word, 1 means byte.
  // - file form takes a direct file address from 0 to 8191.
  // - default working register destination means register zero.
  // - register form decoded with size, mode, register bits, seven trailing zeros.
  // - accumulator shift moves whole 40-bit accumulator by signed 6-bit literal.
  // - count range -16 to 16; negative shifts left, positive shifts right.
  // - bits shifted out are lost, never captured anywhere.
  // - saturation enable bits 7 and 6 saturate results for A and B.
  // - count outside -16..16 leaves accumulator alone and raises trap.
  // - register form takes count from six low bits of the count register.
  // - both shift forms update overflow and saturation flags plus combined ones.
  // - one select bit picks accumulator A or B as source and destination.
*/
package sign_set_acc_pkg;
  localparam int INSTR_W     = 24;
  localparam int DATA_W      = 16;
  localparam int ACC_W       = 40;
  localparam int FADDR_W     = 13;
  localparam int REG_W       = 4;
  localparam int MODE_W      = 3;
  localparam int CNT_W       = 6;
  localparam int EXT_W       = 56;
  localparam int GUARD_LSB   = 31;
  // opcode byte and field positions
  localparam int OPC_MSB     = 23;
  localparam int OPC_LSB     = 16;
  localparam logic [7:0] OPC_SIGN_EXT  = 8'hfb;
  localparam logic [7:0] OPC_ONES_FILE = 8'hef;
  localparam logic [7:0] OPC_ONES_REG  = 8'heb;
  localparam logic [7:0] OPC_ACC_SHIFT = 8'hc8;
  localparam int ONES_MARK_BIT = 15;
  localparam int SIZE_BIT      = 14;
  localparam int DSEL_BIT      = 13;
  localparam int ACC_SEL_BIT   = 15;
  localparam int DMODE_LSB     = 11;
  localparam int DREG_LSB      = 7;
  localparam int SMODE_LSB     = 4;
  localparam int SREG_LSB      = 0;
  localparam int LIT_TAG_LSB   = 6;
  localparam logic [1:0] LIT_TAG = 2'h1;
  // addressing modes
  localparam logic [MODE_W-1:0] MODE_DIRECT   = 3'h0;
  localparam logic [MODE_W-1:0] MODE_IND      = 3'h1;
  localparam logic [MODE_W-1:0] MODE_POST_DEC = 3'h2;
  localparam logic [MODE_W-1:0] MODE_POST_INC = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PRE_DEC  = 3'h4;
  localparam logic [MODE_W-1:0] MODE_PRE_INC  = 3'h5;
  // values
  localparam logic [7:0]        SIGN_FILL    = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ONES    = 16'h00ff;
  localparam logic [DATA_W-1:0] WORD_ONES    = 16'hffff;
  localparam logic [REG_W-1:0]  DEFAULT_REG  = 4'h0;
  localparam logic [1:0]        STEP_BYTE    = 2'h1;
  localparam logic [1:0]        STEP_WORD    = 2'h2;
  localparam int SAT_A_BIT = 7;
  localparam int SAT_B_BIT = 6;
  localparam logic signed [CNT_W-1:0] SHIFT_MIN = -6'sd16;
  localparam logic signed [CNT_W-1:0] SHIFT_MAX = 6'sd16;
  localparam logic [ACC_W-1:0] SAT_POS = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT_NEG = 40'hff80000000;

  // guard bits disagree with bit 31: value left the 32-bit range
  function automatic logic acc_overflow(input logic [ACC_W-1:0] v);
    return !((&v[ACC_W-1:GUARD_LSB]) || !(|v[ACC_W-1:GUARD_LSB]));
  endfunction : acc_overflow

  // modes that move the pointer register
  function automatic logic mode_moves(input logic [MODE_W-1:0] m);
    return (m >= MODE_POST_DEC) && (m <= MODE_PRE_INC);
  endfunction : mode_moves

  function automatic logic mode_legal(input logic [MODE_W-1:0] m);
    return m <= MODE_PRE_INC;
  endfunction : mode_legal
endpackage : sign_set_acc_pkg

// file: design/acc_shift_sat.sv
/*
  Combinational 40-bit arithmetic shifter with optional saturation.
  Assumes the caller rejects counts outside -16..16 before using result.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_shift_sat
  import sign_set_acc_pkg::*;
(
  input  wire logic [ACC_W-1:0]        value_in,
  input  wire logic signed [CNT_W-1:0] count_in,
  input  wire logic                    sat_en_in,
  output logic      [ACC_W-1:0]        result_out,
  output logic                         overflow_out,
  output logic                         saturated_out
);
  logic signed [EXT_W-1:0] wide;
  logic signed [EXT_W-1:0] shifted;
  logic        [CNT_W-1:0] neg_count;
  logic        [4:0]       amount;
  logic                    fits;

  // widen first so a left shift keeps the true sign for saturation
  always_comb begin
    wide      = $signed({{(EXT_W-ACC_W){value_in[ACC_W-1]}}, value_in});
    neg_count = CNT_W'(-count_in);
    amount    = count_in[CNT_W-1] ? neg_count[4:0] : count_in[4:0];
    shifted   = count_in[CNT_W-1] ? (wide <<< amount) : (wide >>> amount);
    fits      = (&shifted[EXT_W-1:GUARD_LSB]) || !(|shifted[EXT_W-1:GUARD_LSB]);
    // clip to the 32-bit range when enabled
    saturated_out = sat_en_in && !fits;
    result_out    = saturated_out ? (shifted[EXT_W-1] ? SAT_NEG : SAT_POS)
                                  : shifted[ACC_W-1:0];
    overflow_out  = acc_overflow(result_out);
  end
endmodule : acc_shift_sat
`default_nettype wire

// file: design/sign_set_acc_shift_unit.sv
/*
  Execute stage for sign-extend, set-all-ones and accumulator shift.
  Holds both accumulators and their overflow / saturation flags.
  Assumes the decoder supplies the fetched source operand and count
  register value in the same cycle as the instruction, and that data
  memory and the register file perform the writes this block requests.
*/
`timescale 1ns/1ps
`default_nettype none
module sign_set_acc_shift_unit
  import sign_set_acc_pkg::*;
(
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               INSTR_VALID_IN,
  input  wire logic [INSTR_W-1:0] INSTR_WORD_IN,
  input  wire logic [DATA_W-1:0]  SRC_DATA_IN,
  input  wire logic [DATA_W-1:0]  COUNT_REG_DATA_IN,
  input  wire logic [DATA_W-1:0]  CORE_CONTROL_WORD_IN,
  input  wire logic               ACC_LOAD_EN_IN,
  input  wire logic               ACC_LOAD_SEL_IN,
  input  wire logic [ACC_W-1:0]   ACC_LOAD_DATA_IN,
  input  wire logic               SAT_FLAG_CLEAR_IN,
  output logic      [REG_W-1:0]   SRC_REG_OUT,
  output logic      [MODE_W-1:0]  SRC_MODE_OUT,
  output logic      [REG_W-1:0]   COUNT_REG_OUT,
  output logic                    WR_EN_OUT,
  output logic                    WR_FILE_OUT,
  output logic      [FADDR_W-1:0] WR_ADDR_OUT,
  output logic      [REG_W-1:0]   WR_REG_OUT,
  output logic      [MODE_W-1:0]  WR_MODE_OUT,
  output logic                    WR_BYTE_OUT,
  output logic      [DATA_W-1:0]  WR_DATA_OUT,
  output logic                    PTR_WE_OUT,
  output logic      [REG_W-1:0]   PTR_REG_OUT,
  output logic      [1:0]         PTR_STEP_OUT,
  output logic                    PTR_DEC_OUT,
  output logic                    FLAG_NZC_WE_OUT,
  output logic                    FLAG_N_OUT,
  output logic                    FLAG_Z_OUT,
  output logic                    FLAG_C_OUT,
  output logic      [ACC_W-1:0]   ACC_A_OUT,
  output logic      [ACC_W-1:0]   ACC_B_OUT,
  output logic                    ACC_A_OVERFLOW_FLAG_OUT,
  output logic                    ACC_B_OVERFLOW_FLAG_OUT,
  output logic                    COMBINED_OVERFLOW_FLAG_OUT,
  output logic                    ACC_A_SATURATED_FLAG_OUT,
  output logic                    ACC_B_SATURATED_FLAG_OUT,
  output logic                    COMBINED_SATURATED_FLAG_OUT,
  output logic                    ARITH_TRAP_OUT,
  output logic                    ILLEGAL_OUT
);
  // decode
  logic [7:0]              opcode;
  logic                    sign_extend_op;
  logic                    ones_file_op;
  logic                    ones_reg_op;
  logic                    accum_arith_shift_op;
  logic                    lit_form;
  logic                    byte_size;
  logic [MODE_W-1:0]       src_mode;
  logic [MODE_W-1:0]       dst_mode;
  logic [REG_W-1:0]        src_reg;
  logic [REG_W-1:0]        dst_reg;
  logic signed [CNT_W-1:0] shift_count;
  logic                    count_ok;
  logic                    acc_sel;
  logic [ACC_W-1:0]        shift_src;
  logic [ACC_W-1:0]        shift_res;
  logic                    shift_ovf;
  logic                    shift_sat;
  logic                    sat_enable;
  logic [DATA_W-1:0]       sext_result;

  // registered state
  logic               wr_en, wr_file, wr_byte, ptr_we, ptr_dec, nzc_we;
  logic               flag_n, flag_z, flag_c, trap, illegal;
  logic [FADDR_W-1:0] wr_addr;
  logic [REG_W-1:0]   wr_reg, ptr_reg;
  logic [MODE_W-1:0]  wr_mode;
  logic [DATA_W-1:0]  wr_data;
  logic [1:0]         ptr_step;
  logic [ACC_W-1:0]   accumulator_a, accumulator_b;
  logic               ovf_a, ovf_b, sat_a, sat_b;

  logic               next_wr_en, next_wr_file, next_wr_byte, next_ptr_we, next_ptr_dec;
  logic               next_nzc_we, next_flag_n, next_flag_z, next_flag_c;
  logic               next_trap, next_illegal;
  logic [FADDR_W-1:0] next_wr_addr;
  logic [REG_W-1:0]   next_wr_reg, next_ptr_reg;
  logic [MODE_W-1:0]  next_wr_mode;
  logic [DATA_W-1:0]  next_wr_data;
  logic [1:0]         next_ptr_step;
  logic [ACC_W-1:0]   next_acc_a, next_acc_b;
  logic               next_ovf_a, next_ovf_b, next_sat_a, next_sat_b;

  // field extraction and opcode match
  always_comb begin
    opcode    = INSTR_WORD_IN[OPC_MSB:OPC_LSB];
    byte_size = INSTR_WORD_IN[SIZE_BIT];
    src_mode  = INSTR_WORD_IN[SMODE_LSB +: MODE_W];
    dst_mode  = INSTR_WORD_IN[DMODE_LSB +: MODE_W];
    src_reg   = INSTR_WORD_IN[SREG_LSB +: REG_W];
    dst_reg   = INSTR_WORD_IN[DREG_LSB +: REG_W];
    acc_sel   = INSTR_WORD_IN[ACC_SEL_BIT];
    lit_form  = INSTR_WORD_IN[LIT_TAG_LSB +: 2] == LIT_TAG;
    sign_extend_op = (opcode == OPC_SIGN_EXT) && (INSTR_WORD_IN[15:11] == 5'h00);
    ones_file_op   = (opcode == OPC_ONES_FILE) && INSTR_WORD_IN[ONES_MARK_BIT];
    ones_reg_op    = (opcode == OPC_ONES_REG) && INSTR_WORD_IN[ONES_MARK_BIT]
                     && (INSTR_WORD_IN[6:0] == 7'h00);
    accum_arith_shift_op = (opcode == OPC_ACC_SHIFT) && (INSTR_WORD_IN[14:8] == 7'h00)
                     && (lit_form || (INSTR_WORD_IN[7:4] == 4'h0));
    // literal or count register low six bits
    shift_count = lit_form ? $signed(INSTR_WORD_IN[CNT_W-1:0])
                           : $signed(COUNT_REG_DATA_IN[CNT_W-1:0]);
    count_ok    = (shift_count >= SHIFT_MIN) && (shift_count <= SHIFT_MAX);
    // one bit picks source and destination accumulator
    shift_src   = acc_sel ? accumulator_b : accumulator_a;
    sat_enable  = acc_sel ? CORE_CONTROL_WORD_IN[SAT_B_BIT] : CORE_CONTROL_WORD_IN[SAT_A_BIT];
    // sign fill of the upper byte
    sext_result = {SRC_DATA_IN[7] ? SIGN_FILL : 8'h00, SRC_DATA_IN[7:0]};
  end

  acc_shift_sat u_shift (
    .value_in      (shift_src),
    .count_in      (shift_count),
    .sat_en_in     (sat_enable),
    .result_out    (shift_res),
    .overflow_out  (shift_ovf),
    .saturated_out (shift_sat)
  );

  // operand fetch request is combinational so the decoder can return data this cycle
  assign SRC_REG_OUT   = src_reg;
  assign SRC_MODE_OUT  = src_mode;
  assign COUNT_REG_OUT = src_reg;

  // next values for write-back, flags and accumulators
  always_comb begin
    next_wr_en    = 1'b0;
    next_wr_file  = 1'b0;
    next_wr_byte  = 1'b0;
    next_wr_addr  = '0;
    next_wr_reg   = '0;
    next_wr_mode  = MODE_DIRECT;
    next_wr_data  = wr_data;
    next_ptr_we   = 1'b0;
    next_ptr_reg  = '0;
    next_ptr_step = STEP_WORD;
    next_ptr_dec  = 1'b0;
    next_nzc_we   = 1'b0;
    next_flag_n   = flag_n;
    next_flag_z   = flag_z;
    next_flag_c   = flag_c;
    next_trap     = 1'b0;
    next_illegal  = 1'b0;
    next_acc_a    = accumulator_a;
    next_acc_b    = accumulator_b;
    next_ovf_a    = ovf_a;
    next_ovf_b    = ovf_b;
    // saturation flags are sticky; a set in the clearing cycle wins
    next_sat_a    = sat_a && !SAT_FLAG_CLEAR_IN;
    next_sat_b    = sat_b && !SAT_FLAG_CLEAR_IN;
    // outside loads land first; an executing shift overrides them below
    if (ACC_LOAD_EN_IN && !ACC_LOAD_SEL_IN) begin
      next_acc_a = ACC_LOAD_DATA_IN;
    end
    if (ACC_LOAD_EN_IN && ACC_LOAD_SEL_IN) begin
      next_acc_b = ACC_LOAD_DATA_IN;
    end
    if (INSTR_VALID_IN) begin
      if (sign_extend_op) begin
        // source modes 6 and 7 do not exist here
        if (!mode_legal(src_mode)) begin
          next_illegal = 1'b1;
        end else begin
          next_wr_en   = 1'b1;
          next_wr_reg  = dst_reg;
          next_wr_data = sext_result;
          // N from bit 15, Z on zero, C is not N
          next_nzc_we  = 1'b1;
          next_flag_n  = sext_result[DATA_W-1];
          next_flag_z  = sext_result == '0;
          next_flag_c  = !sext_result[DATA_W-1];
          next_ptr_we   = mode_moves(src_mode);
          next_ptr_reg  = src_reg;
          next_ptr_step = STEP_BYTE;
          next_ptr_dec  = (src_mode == MODE_POST_DEC) || (src_mode == MODE_PRE_DEC);
        end
      end else if (ones_file_op) begin
        // fill value by size, flags left alone
        next_wr_en   = 1'b1;
        next_wr_byte = byte_size;
        next_wr_data = byte_size ? BYTE_ONES : WORD_ONES;
        // destination bit picks file or register zero
        next_wr_file = INSTR_WORD_IN[DSEL_BIT];
        next_wr_addr = INSTR_WORD_IN[FADDR_W-1:0];
        next_wr_reg  = DEFAULT_REG;
      end else if (ones_reg_op) begin
        if (!mode_legal(dst_mode)) begin
          next_illegal = 1'b1;
        end else begin
          next_wr_en    = 1'b1;
          next_wr_byte  = byte_size;
          next_wr_data  = byte_size ? BYTE_ONES : WORD_ONES;
          next_wr_reg   = dst_reg;
          next_wr_mode  = dst_mode;
          next_ptr_we   = mode_moves(dst_mode);
          next_ptr_reg  = dst_reg;
          next_ptr_step = byte_size ? STEP_BYTE : STEP_WORD;
          next_ptr_dec  = (dst_mode == MODE_POST_DEC) || (dst_mode == MODE_PRE_DEC);
        end
      end else if (accum_arith_shift_op) begin
        if (!count_ok) begin
          next_trap  = 1'b1;
          next_acc_a = accumulator_a;
          next_acc_b = accumulator_b;
        end else begin
          // both overflow flags refreshed; only the selected accumulator's saturation flag is set
          if (acc_sel) begin
            next_acc_b = shift_res;
            next_acc_a = accumulator_a;
            next_ovf_b = shift_ovf;
            next_ovf_a = acc_overflow(accumulator_a);
            next_sat_b = next_sat_b || shift_sat;
          end else begin
            next_acc_a = shift_res;
            next_acc_b = accumulator_b;
            next_ovf_a = shift_ovf;
            next_ovf_b = acc_overflow(accumulator_b);
            next_sat_a = next_sat_a || shift_sat;
          end
        end
      end else begin
        next_illegal = 1'b1;
      end
    end
  end

  // register every next value
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_en <= 1'b0;  wr_file <= 1'b0;  wr_byte <= 1'b0;  wr_addr <= '0;
      wr_reg <= '0;   wr_mode <= MODE_DIRECT;  wr_data <= '0;
      ptr_we <= 1'b0; ptr_reg <= '0;  ptr_step <= STEP_WORD;  ptr_dec <= 1'b0;
      nzc_we <= 1'b0; flag_n <= 1'b0; flag_z <= 1'b0;  flag_c <= 1'b0;
      trap <= 1'b0;   illegal <= 1'b0;
      accumulator_a <= '0;  accumulator_b <= '0;
      ovf_a <= 1'b0;  ovf_b <= 1'b0;  sat_a <= 1'b0;  sat_b <= 1'b0;
    end else begin
      wr_en <= next_wr_en;  wr_file <= next_wr_file;  wr_byte <= next_wr_byte;
      wr_addr <= next_wr_addr;  wr_reg <= next_wr_reg;  wr_mode <= next_wr_mode;
      wr_data <= next_wr_data;  ptr_we <= next_ptr_we;  ptr_reg <= next_ptr_reg;
      ptr_step <= next_ptr_step;  ptr_dec <= next_ptr_dec;  nzc_we <= next_nzc_we;
      flag_n <= next_flag_n;  flag_z <= next_flag_z;  flag_c <= next_flag_c;
      trap <= next_trap;  illegal <= next_illegal;
      accumulator_a <= next_acc_a;  accumulator_b <= next_acc_b;
      ovf_a <= next_ovf_a;  ovf_b <= next_ovf_b;  sat_a <= next_sat_a;  sat_b <= next_sat_b;
    end
  end

  assign WR_EN_OUT       = wr_en;
  assign WR_FILE_OUT     = wr_file;
  assign WR_ADDR_OUT     = wr_addr;
  assign WR_REG_OUT      = wr_reg;
  assign WR_MODE_OUT     = wr_mode;
  assign WR_BYTE_OUT     = wr_byte;
  assign WR_DATA_OUT     = wr_data;
  assign PTR_WE_OUT      = ptr_we;
  assign PTR_REG_OUT     = ptr_reg;
  assign PTR_STEP_OUT    = ptr_step;
  assign PTR_DEC_OUT     = ptr_dec;
  assign FLAG_NZC_WE_OUT = nzc_we;
  assign FLAG_N_OUT      = flag_n;
  assign FLAG_Z_OUT      = flag_z;
  assign FLAG_C_OUT      = flag_c;
  assign ACC_A_OUT       = accumulator_a;
  assign ACC_B_OUT       = accumulator_b;
  assign ARITH_TRAP_OUT  = trap;
  assign ILLEGAL_OUT     = illegal;
  assign ACC_A_OVERFLOW_FLAG_OUT     = ovf_a;
  assign ACC_B_OVERFLOW_FLAG_OUT     = ovf_b;
  assign COMBINED_OVERFLOW_FLAG_OUT  = ovf_a || ovf_b;
  assign ACC_A_SATURATED_FLAG_OUT    = sat_a;
  assign ACC_B_SATURATED_FLAG_OUT    = sat_b;
  assign COMBINED_SATURATED_FLAG_OUT = sat_a || sat_b;

  // checks on the registered results
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  chk_sext_byte_fill: assert property (
    INSTR_VALID_IN && sign_extend_op && mode_legal(src_mode) |=>
      WR_EN_OUT && WR_DATA_OUT[7:0] == $past(SRC_DATA_IN[7:0]) &&
      WR_DATA_OUT[15:8] == ($past(SRC_DATA_IN[7]) ? 8'hff : 8'h00))
    else $error("sign extend result wrong");

  chk_sext_carry_flag: assert property (
    FLAG_NZC_WE_OUT |-> FLAG_C_OUT == !FLAG_N_OUT && FLAG_N_OUT == WR_DATA_OUT[15]
      && FLAG_Z_OUT == (WR_DATA_OUT == 16'h0000))
    else $error("sign extend flags wrong");

  chk_sext_dest_direct: assert property (
    INSTR_VALID_IN && sign_extend_op |=> WR_MODE_OUT == MODE_DIRECT && !WR_FILE_OUT)
    else $error("sign extend destination not direct");

  chk_sext_ptr_step: assert property (
    INSTR_VALID_IN && sign_extend_op && mode_moves(src_mode) |=>
      PTR_WE_OUT && PTR_STEP_OUT == 2'h1 && PTR_REG_OUT == $past(src_reg))
    else $error("sign extend pointer step wrong");

  chk_ones_fill_value: assert property (
    INSTR_VALID_IN && (ones_file_op || (ones_reg_op && mode_legal(dst_mode))) |=>
      WR_EN_OUT && !FLAG_NZC_WE_OUT &&
      WR_DATA_OUT == ($past(byte_size) ? 16'h00ff : 16'hffff) && WR_BYTE_OUT == $past(byte_size))
    else $error("set all ones value wrong");

  chk_ones_default_reg: assert property (
    INSTR_VALID_IN && ones_file_op && !INSTR_WORD_IN[DSEL_BIT] |=>
      !WR_FILE_OUT && WR_REG_OUT == 4'h0)
    else $error("default register not zero");

  chk_ones_file_addr: assert property (
    INSTR_VALID_IN && ones_file_op && INSTR_WORD_IN[DSEL_BIT] |=>
      WR_FILE_OUT && WR_ADDR_OUT == $past(INSTR_WORD_IN[12:0]))
    else $error("file address wrong");

  chk_trap_keeps_acc: assert property (
    INSTR_VALID_IN && accum_arith_shift_op && !count_ok && !ACC_LOAD_EN_IN |=>
      ARITH_TRAP_OUT && $stable(ACC_A_OUT) && $stable(ACC_B_OUT))
    else $error("out of range shift modified accumulator");

  chk_other_acc_kept: assert property (
    INSTR_VALID_IN && accum_arith_shift_op && count_ok && !acc_sel && !ACC_LOAD_EN_IN |=>
      $stable(ACC_B_OUT) && !ARITH_TRAP_OUT)
    else $error("wrong accumulator written");

  chk_ovf_tracks_acc: assert property (
    INSTR_VALID_IN && accum_arith_shift_op && count_ok |=>
      ACC_A_OVERFLOW_FLAG_OUT == acc_overflow(ACC_A_OUT) &&
      ACC_B_OVERFLOW_FLAG_OUT == acc_overflow(ACC_B_OUT))
    else $error("overflow flag does not match accumulator");
endmodule : sign_set_acc_shift_unit
`default_nettype wire

// file: test/core_side_model.sv
/*
  core side model: working register file that feeds operands to the unit.
  assumes reads are combinational, indexed by the unit's request outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module core_side_model
  import sign_set_acc_pkg::*;
(
  input  wire logic [REG_W-1:0]  src_reg_in,
  input  wire logic [REG_W-1:0]  count_reg_in,
  output logic      [DATA_W-1:0] src_data_out,
  output logic      [DATA_W-1:0] count_data_out
);
  logic [DATA_W-1:0] regs [16];
  // cleared so no unknown operand reaches the unit
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  task automatic put(input logic [REG_W-1:0] idx, input logic [DATA_W-1:0] val);
    regs[idx] = val;
  endtask : put
  assign src_data_out   = regs[src_reg_in];
  assign count_data_out = regs[count_reg_in];
endmodule : core_side_model
`default_nettype wire

// file: test/tb.sv
/*
  testbench: issues instructions every other cycle and checks registered results.
  assumes one cycle latency and operands presented with the instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sign_set_acc_pkg::*;
  logic clk, rst, vld, ld_en, ld_sel, sclr;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  src_d, cnt_d, ccw, wr_data;
  logic [ACC_W-1:0]   ld_d, acc_a, acc_b;
  logic [REG_W-1:0]   sreg, creg, wr_reg, ptr_reg;
  logic [MODE_W-1:0]  wr_mode, smode;
  logic [FADDR_W-1:0] wr_addr;
  logic [1:0]         ptr_step;
  logic wr_en, wr_file, wr_byte, ptr_we, ptr_dec, nzc_we, fn, fz, fc;
  logic ova, ovb, ovc, sat_a, sat_b, sc, trap, ill;
  int fails = 0;
  int cmp_count = 0;
  sign_set_acc_shift_unit sign_set_acc_shift_unit_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
    .INSTR_VALID_IN(vld), .INSTR_WORD_IN(instr), .SRC_DATA_IN(src_d),
    .COUNT_REG_DATA_IN(cnt_d), .CORE_CONTROL_WORD_IN(ccw), .ACC_LOAD_EN_IN(ld_en),
    .ACC_LOAD_SEL_IN(ld_sel), .ACC_LOAD_DATA_IN(ld_d), .SAT_FLAG_CLEAR_IN(sclr),
    .SRC_REG_OUT(sreg), .SRC_MODE_OUT(smode), .COUNT_REG_OUT(creg), .WR_EN_OUT(wr_en),
    .WR_FILE_OUT(wr_file), .WR_ADDR_OUT(wr_addr), .WR_REG_OUT(wr_reg), .WR_MODE_OUT(wr_mode),
    .WR_BYTE_OUT(wr_byte), .WR_DATA_OUT(wr_data), .PTR_WE_OUT(ptr_we), .PTR_REG_OUT(ptr_reg),
    .PTR_STEP_OUT(ptr_step), .PTR_DEC_OUT(ptr_dec), .FLAG_NZC_WE_OUT(nzc_we), .FLAG_N_OUT(fn),
    .FLAG_Z_OUT(fz), .FLAG_C_OUT(fc), .ACC_A_OUT(acc_a), .ACC_B_OUT(acc_b),
    .ACC_A_OVERFLOW_FLAG_OUT(ova), .ACC_B_OVERFLOW_FLAG_OUT(ovb),
    .COMBINED_OVERFLOW_FLAG_OUT(ovc), .ACC_A_SATURATED_FLAG_OUT(sat_a),
    .ACC_B_SATURATED_FLAG_OUT(sat_b), .COMBINED_SATURATED_FLAG_OUT(sc),
    .ARITH_TRAP_OUT(trap), .ILLEGAL_OUT(ill));
  core_side_model core_side_model_inst (.src_reg_in(sreg), .count_reg_in(creg),
    .src_data_out(src_d), .count_data_out(cnt_d));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // wide enough for a whole accumulator plus its flags, so nothing is cut off
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one instruction, results stand during the following cycle
  task automatic run(input logic [INSTR_W-1:0] w);
    @(posedge clk);
    #1 vld = 1'b1;
    instr = w;
    @(posedge clk);
    #1 vld = 1'b0;
  endtask : run
  task automatic load(input logic sel, input logic [ACC_W-1:0] v);
    @(posedge clk);
    #1 ld_en = 1'b1;
    ld_sel = sel;
    ld_d = v;
    @(posedge clk);
    #1 ld_en = 1'b0;
  endtask : load
  // hang guard: a run that stalls still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    rst = 1'b1; vld = 1'b0; ld_en = 1'b0; ld_sel = 1'b0; sclr = 1'b0;
    instr = 24'h000000; ccw = 16'h0000; ld_d = 40'h0000000000;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    core_side_model_inst.put(4'h3, 16'h7839);
    core_side_model_inst.put(4'h2, 16'h008f);
    run(24'hfb0203);
    chk("sext write", {1'b1, 1'b0, 4'h4, 16'h0039}, {wr_en, wr_file, wr_reg, wr_data});
    chk("sext flags", 4'b1001, {nzc_we, fn, fz, fc});
    run(24'hfb0632);
    chk("sext neg", {4'hc, 16'hff8f, 4'b1100}, {wr_reg, wr_data, nzc_we, fn, fz, fc});
    chk("sext ptr", {1'b1, 2'h1, 1'b0, 4'h2}, {ptr_we, ptr_step, ptr_dec, ptr_reg});
    chk("sext src mode", 3'h3, smode);
    $display("test sign extend done");
    run(24'hefe891);
    chk("ones file", {3'b111, 13'h0891, 16'h00ff}, {wr_en, wr_file, wr_byte, wr_addr, wr_data});
    run(24'hef8000);
    chk("ones default", {3'b100, 4'h0, 16'hffff}, {wr_en, wr_file, wr_byte, wr_reg, wr_data});
    chk("ones flags", 4'b0100, {nzc_we, fn, fz, fc});
    run(24'heba300);
    chk("ones reg", {2'b10, 3'h4, 4'h6, 16'hffff}, {wr_en, wr_file, wr_mode, wr_reg, wr_data});
    chk("ones reg ptr", {1'b1, 2'h2, 1'b1, 4'h6}, {ptr_we, ptr_step, ptr_dec, ptr_reg});
    run(24'hebb000);
    chk("ones bad mode", 2'b01, {wr_en, ill});
    $display("test set all ones done");
    load(1'b0, 40'h00120fff00);
    ccw = 16'h0080;
    run(24'hc8004c);
    chk("shift lit a", 40'h00000120ff, acc_a);
    load(1'b1, 40'hfffff18f4c);
    ccw = 16'h0040;
    run(24'hc88076);
    chk("shift left b", {40'hffc63d3000, 6'h00}, {acc_b, ova, ovb, ovc, sat_a, sat_b, sc});
    ccw = 16'h0000;
    core_side_model_inst.put(4'h0, 16'hfffc);
    load(1'b0, 40'h00320fab09);
    run(24'hc80000);
    chk("shift reg a", {40'h0320fab090, 3'b101}, {acc_a, ova, ovb, ovc});
    run(24'hc80051);
    chk("trap high", {1'b1, 40'h0320fab090}, {trap, acc_a});
    run(24'hc8006f);
    chk("trap low", {1'b1, 40'h0320fab090}, {trap, acc_a});
    load(1'b1, 40'hff80000000);
    run(24'hc88050);
    chk("shift right b", {40'hffffff8000, 1'b0}, {acc_b, nzc_we});
    ccw = 16'h0080;
    load(1'b0, 40'h0040000000);
    run(24'hc8007f);
    chk("saturate a", {40'h007fffffff, 3'b101}, {acc_a, sat_a, sat_b, sc});
    @(posedge clk);
    #1 sclr = 1'b1;
    @(posedge clk);
    #1 sclr = 1'b0;
    chk("sat clear", 3'b000, {sat_a, sat_b, sc});
    $display("test accumulator shift done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
